// ===== hdl/homing_params.svh
// Constants of the homing sequence selector: method codes and widths
//
// Behaviour
// (R1) Method 0 default, no homing, position kept
// (R2) Method 0 presents position saved at power-off
// (R3) Method 1: negative limit, then zero pulse
// (R4) Method 2: positive limit, then zero pulse
// (R5) Methods 3,4: home switch positive, zero pulse
// (R6) Methods 5,6: home switch negative, zero pulse
// (R7) Methods 3-6: first zero pulse past edge
// (R8) Methods 7-10: start positive, zero pulse
// (R9) Methods 7-10: reverse at positive limit
// (R10) Methods 7-10: zero pulse by edge side
// (R11) Methods 11-14: start negative, zero pulse
// (R12) Methods 11-14: reverse at negative limit
// (R13) Methods 11-14: zero pulse by edge side
// (R14) Methods 17-30: as 1-14, no zero pulse
// (R15) Method 17: negative limit is reference
// (R16) Method 18: positive limit is reference
// (R17) Methods 19,20: home switch positive, edge side
// (R18) Methods 21,22: home switch negative, edge side
// (R19) Methods 33,34: first zero pulse neg/pos
// (R20) Method 35: current position, load home offset
// (R21) Undefined methods invalid, no motion
`ifndef HOMING_PARAMS_SVH
`define HOMING_PARAMS_SVH

// --------------------------------------------------------------
// Widths
// --------------------------------------------------------------
`define HOMING_METHOD_W 6
`define HOMING_POS_W 32

// --------------------------------------------------------------
// Method codes
// --------------------------------------------------------------
`define HOMING_M_NONE 6'h00
`define HOMING_M_ZP_LAST 6'h0e
`define HOMING_M_SW_FIRST 6'h11
`define HOMING_M_SW_LAST 6'h1e
`define HOMING_M_SW_SHIFT 6'h10
`define HOMING_M_ZP_NEG 6'h21
`define HOMING_M_ZP_POS 6'h22
`define HOMING_M_HERE 6'h23

// --------------------------------------------------------------
// Reset values
// --------------------------------------------------------------
`define HOMING_POS_RESET 32'h0000_0000

`endif

// ===== hdl/homing_pkg.sv
// Types shared by the homing sequence selector
package homing_pkg;

  // Sequencer states
  typedef enum logic [1:0] {
    st_idle,
    st_seek,
    st_final
  } state_type;

  // Decoded description of one homing method
  typedef struct packed {
    logic valid;      // Known method code
    logic motion;     // Method moves the axis at all
    logic use_zero;   // Reference fixed by encoder zero pulse
    logic to_limit;   // Target is a hardware limit switch
    logic to_home;    // Target is a home switch edge
    logic start_pos;  // First direction of travel is positive
    logic reverse_ok; // Limit in travel direction turns the axis
    logic edge_left;  // Wanted edge is the left (negative) edge
    logic ref_left;   // Reference lies left of the edge
    logic load_here;  // Current position becomes reference
  } method_cfg_type;

endpackage

// ===== hdl/homing_sequence_selector.sv
// Homing sequencer: selects and runs the reference search method
`timescale 1ns/10ps
`include "homing_params.svh"

module homing_sequence_selector (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [`HOMING_METHOD_W-1:0] method,
  input wire logic start,
  input wire logic abort,
  input wire logic [`HOMING_POS_W-1:0] saved_pos,
  input wire logic [`HOMING_POS_W-1:0] home_offset,
  input wire logic [`HOMING_POS_W-1:0] enc_count,
  input wire logic lim_pos_pin,
  input wire logic lim_neg_pin,
  input wire logic home_sw_pin,
  input wire logic enc_zero_pin,
  output logic move_pos,
  output logic move_neg,
  output logic busy,
  output logic homed,
  output logic invalid,
  output logic fault,
  output logic ref_strobe,
  output logic [`HOMING_POS_W-1:0] ref_pos,
  output logic [`HOMING_POS_W-1:0] position
);

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  // Async assert, synchronous release
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [3:0] pin_raw;
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic lim_pos;
  logic lim_neg;
  logic home_sw;
  logic zero_now;
  logic home_prev;
  logic zero_prev;

  assign pin_raw = {enc_zero_pin, home_sw_pin, lim_neg_pin, lim_pos_pin};

  // Two stages per switch; first stage read only by the second
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          pin_meta[gi] <= 1'b0;
          pin_sync[gi] <= 1'b0;
        end else begin
          pin_meta[gi] <= pin_raw[gi];
          pin_sync[gi] <= pin_meta[gi];
        end
      end
    end
  endgenerate

  assign lim_pos = pin_sync[0];
  assign lim_neg = pin_sync[1];
  assign home_sw = pin_sync[2];
  assign zero_now = pin_sync[3];

  // Previous samples for edge detection
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      home_prev <= 1'b0;
      zero_prev <= 1'b0;
    end else begin
      home_prev <= home_sw;
      zero_prev <= zero_now;
    end
  end

  // ------------------------------------------------------------
  // Method decode
  // ------------------------------------------------------------
  // Methods 1..14 share one table; 17..30 reuse it minus zero pulse
  function automatic homing_pkg::method_cfg_type decode(
    input logic [`HOMING_METHOD_W-1:0] code
  );
    homing_pkg::method_cfg_type c;
    logic [`HOMING_METHOD_W-1:0] base;
    logic zp;
    c = '0;
    base = code;
    zp = 1'b1;
    // (R14) Switch-only family
    if (code >= `HOMING_M_SW_FIRST && code <= `HOMING_M_SW_LAST) begin
      base = code - `HOMING_M_SW_SHIFT;
      zp = 1'b0;
    end
    c.use_zero = zp;
    case (base)
      // (R1) No homing at all
      `HOMING_M_NONE: begin
        c.valid = (code == `HOMING_M_NONE);
      end
      // (R3) (R15) Negative limit, reference then positive side
      6'h01: begin
        c.to_limit = 1'b1;
      end
      // (R4) (R16) Positive limit
      6'h02: begin
        c.to_limit = 1'b1;
        c.start_pos = 1'b1;
        c.ref_left = 1'b1;
      end
      // (R5) (R7) (R17) Positive home switch, left edge
      6'h03: begin
        c.start_pos = 1'b1;
        c.edge_left = 1'b1;
        c.ref_left = 1'b1;
      end
      6'h04: begin
        c.start_pos = 1'b1;
        c.edge_left = 1'b1;
      end
      // (R6) (R7) (R18) Negative home switch, right edge
      6'h05: begin
      end
      6'h06: begin
        c.ref_left = 1'b1;
      end
      // (R8) (R10) Positive start, edge and side per method
      6'h07: begin
        c.start_pos = 1'b1;
        c.edge_left = 1'b1;
        c.ref_left = 1'b1;
      end
      6'h08: begin
        c.start_pos = 1'b1;
        c.edge_left = 1'b1;
      end
      6'h09: begin
        c.start_pos = 1'b1;
        c.ref_left = 1'b1;
      end
      6'h0a: begin
        c.start_pos = 1'b1;
      end
      // (R11) (R13) Negative start, edge and side per method
      6'h0b: begin
      end
      6'h0c: begin
        c.ref_left = 1'b1;
      end
      6'h0d: begin
        c.edge_left = 1'b1;
      end
      6'h0e: begin
        c.edge_left = 1'b1;
        c.ref_left = 1'b1;
      end
      // (R19) Zero pulse only, no switch
      `HOMING_M_ZP_NEG: begin
        c.ref_left = 1'b1;
      end
      `HOMING_M_ZP_POS: begin
      end
      // (R20) Take current position
      `HOMING_M_HERE: begin
        c.load_here = 1'b1;
        c.use_zero = 1'b0;
      end
      // (R21) Anything else is not a method
      default: begin
        c.use_zero = 1'b0;
      end
    endcase
    if (base != `HOMING_M_NONE && (base <= `HOMING_M_ZP_LAST ||
        code == `HOMING_M_ZP_NEG || code == `HOMING_M_ZP_POS ||
        code == `HOMING_M_HERE)) begin
      c.valid = 1'b1;
    end
    c.motion = c.valid && !c.load_here && base != `HOMING_M_NONE;
    c.to_home = c.motion && !c.to_limit && base <= `HOMING_M_ZP_LAST;
    // (R9) (R12) Turn at the limit only in methods 7..14 and kin
    c.reverse_ok = base >= 6'h07 && base <= `HOMING_M_ZP_LAST;
    return c;
  endfunction

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  homing_pkg::state_type state;
  homing_pkg::method_cfg_type cfg;
  homing_pkg::method_cfg_type new_cfg;
  logic dir_pos;
  logic home_rise;
  logic home_fall;
  logic cross_left;
  logic cross_right;
  logic edge_hit;
  logic limit_ahead;
  logic limit_hit;
  logic zero_rise;
  logic take_ref;
  logic fail;

  assign new_cfg = decode(method);
  assign home_rise = home_sw && !home_prev;
  assign home_fall = !home_sw && home_prev;
  // Edge side from direction of travel at the switch change
  assign cross_left = (home_rise && dir_pos) || (home_fall && !dir_pos);
  assign cross_right = (home_fall && dir_pos) || (home_rise && !dir_pos);
  assign edge_hit = cfg.to_home && (cfg.edge_left ? cross_left : cross_right); // Cam ignored by limit methods
  assign limit_ahead = dir_pos ? lim_pos : lim_neg;
  assign limit_hit = cfg.start_pos ? lim_pos : lim_neg;
  assign zero_rise = zero_now && !zero_prev;

  // Reference event in the final approach
  assign take_ref = (state == homing_pkg::st_final) && zero_rise;

  // A limit reached where no turn is allowed ends the search
  assign fail = (state != homing_pkg::st_idle) && limit_ahead &&
                !cfg.reverse_ok &&
                !(state == homing_pkg::st_seek && cfg.to_limit);

  // Method state, direction and phase
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= homing_pkg::st_idle;
      cfg <= '0;
      dir_pos <= 1'b0;
    end else if (abort || fail) begin
      state <= homing_pkg::st_idle;
    end else begin
      case (state)
        homing_pkg::st_idle: begin
          if (start && new_cfg.motion) begin
            cfg <= new_cfg;
            // Already on the switch: the wanted edge lies behind
            dir_pos <= new_cfg.start_pos ^
                       (new_cfg.to_home && !new_cfg.reverse_ok && home_sw);
            if (!new_cfg.to_limit && !new_cfg.to_home) begin
              // (R19) Straight to the zero pulse search
              dir_pos <= !new_cfg.ref_left;
              state <= homing_pkg::st_final;
            end else begin
              state <= homing_pkg::st_seek;
            end
          end
        end
        homing_pkg::st_seek: begin
          if (cfg.to_limit && limit_hit) begin
            // (R3) (R4) Leave the limit toward the zero pulse
            dir_pos <= !cfg.ref_left;
            state <= cfg.use_zero ? homing_pkg::st_final : homing_pkg::st_idle;
          end else if (edge_hit) begin
            // (R7) (R10) (R13) Past the edge, look on the chosen side
            dir_pos <= !cfg.ref_left;
            state <= cfg.use_zero ? homing_pkg::st_final : homing_pkg::st_idle;
          end else if (cfg.reverse_ok && limit_ahead) begin
            // (R9) (R12) Turn back at the limit
            dir_pos <= !dir_pos;
          end
        end
        homing_pkg::st_final: begin
          if (zero_rise) begin
            state <= homing_pkg::st_idle;
          end
        end
        default: begin
          state <= homing_pkg::st_idle;
        end
      endcase
    end
  end

  // Switch-only reference, taken without a zero pulse
  logic take_sw;
  assign take_sw = (state == homing_pkg::st_seek) && !cfg.use_zero &&
                   !abort && ((cfg.to_limit && limit_hit) || edge_hit);

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  logic next_move;
  assign next_move = !(abort || fail);

  // Drive requests follow the sequencer, none when idle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      move_pos <= 1'b0;
      move_neg <= 1'b0;
      busy <= 1'b0;
    end else begin
      busy <= state != homing_pkg::st_idle && next_move &&
              !take_ref && !take_sw;
      move_pos <= state != homing_pkg::st_idle && next_move &&
                  !take_ref && !take_sw && dir_pos;
      move_neg <= state != homing_pkg::st_idle && next_move &&
                  !take_ref && !take_sw && !dir_pos;
    end
  end

  // Reference capture; encoder count latched at the event
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_strobe <= 1'b0;
      ref_pos <= `HOMING_POS_RESET;
    end else begin
      ref_strobe <= (take_ref && !abort && !fail) || take_sw ||
                    (state == homing_pkg::st_idle && start &&
                     new_cfg.load_here);
      if ((take_ref && !abort && !fail) || take_sw ||
          (state == homing_pkg::st_idle && start && new_cfg.load_here)) begin
        ref_pos <= enc_count;
      end
    end
  end

  // Status flags: homed survives until a new start
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      homed <= 1'b0;
      invalid <= 1'b0;
      fault <= 1'b0;
    end else begin
      if (state == homing_pkg::st_idle && start) begin
        // (R21) Unknown code is flagged and starts nothing
        invalid <= !new_cfg.valid;
        fault <= 1'b0;
        homed <= new_cfg.load_here;
      end else begin
        if ((take_ref && !abort && !fail) || take_sw) begin
          homed <= 1'b1;
        end
        if (fail) begin
          fault <= 1'b1;
        end
      end
    end
  end

  // Position in effect: saved value, or offset for method 35
  logic loaded;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      loaded <= 1'b0;
      position <= `HOMING_POS_RESET;
    end else if (!loaded) begin
      // (R2) Caught after release, not under reset
      loaded <= 1'b1;
      position <= saved_pos;
    end else if (state == homing_pkg::st_idle && start &&
                 new_cfg.load_here) begin
      // (R20) Home offset becomes the actual position
      position <= home_offset;
    end
  end
  // (R1) Method 0 leaves position untouched: no branch above fires

endmodule // homing_sequence_selector

// ===== bench/axis_model.sv
// Behavioural axis: motor, encoder, limit switches and home cam
`timescale 1ns/10ps
`include "homing_params.svh"
module axis_model (
  input wire logic sys_clk,
  input wire logic move_pos,
  input wire logic move_neg,
  output logic [`HOMING_POS_W-1:0] enc_count,
  output logic lim_pos_pin,
  output logic lim_neg_pin,
  output logic home_sw_pin,
  output logic enc_zero_pin
);
  // Slow travel, so the count stays put across the pin sync delay
  localparam int STEP = 16;
  int pos = 40;
  int tick = 0;
  // One count per STEP cycles in the requested direction
  always @(posedge sys_clk) begin
    tick <= (tick + 1) % STEP;
    if (tick == 0 && move_pos && !move_neg) begin
      pos <= pos + 1;
    end else if (tick == 0 && move_neg && !move_pos) begin
      pos <= pos - 1;
    end
  end
  // Track: limits at 0 and 100, cam 60 to 80, index at 5 modulo 16
  assign enc_count = pos;
  assign lim_neg_pin = (pos <= 0);
  assign lim_pos_pin = (pos >= 100);
  assign home_sw_pin = (pos >= 60) && (pos <= 80);
  assign enc_zero_pin = ((pos & 15) == 5);
endmodule // axis_model

// ===== bench/homing_checker_props.sv
// Port checker of the homing sequence selector
`timescale 1ns/10ps
`include "homing_params.svh"
module homing_checker (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [`HOMING_METHOD_W-1:0] method,
  input wire logic start,
  input wire logic abort,
  input wire logic [`HOMING_POS_W-1:0] saved_pos,
  input wire logic [`HOMING_POS_W-1:0] home_offset,
  input wire logic lim_pos_pin,
  input wire logic lim_neg_pin,
  input wire logic move_pos,
  input wire logic move_neg,
  input wire logic busy,
  input wire logic homed,
  input wire logic invalid,
  input wire logic ref_strobe,
  input wire logic [`HOMING_POS_W-1:0] position
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // ----------
  // Sequences
  // ----------
  sequence s_go;
    start && !busy && !abort;
  endsequence
  sequence s_neg_hit;
    (move_neg && lim_neg_pin) [*3];
  endsequence
  sequence s_pos_hit;
    (move_pos && lim_pos_pin) [*3];
  endsequence
  AST_SAVED: assert property ($rose(resetn) |-> ##[3:5] position == saved_pos)
    else $error("saved position not loaded");
  AST_M0_IDLE: assert property (s_go ##0 (method == `HOMING_M_NONE) |=>
    (!busy && !move_pos && !move_neg && $stable(position)) [*3]) else $error("method zero moved");
  AST_BAD: assert property (s_go ##0 (method inside {6'h0f, 6'h10, 6'h1f, 6'h20}) |=>
    invalid && !busy ##1 (!busy && !move_pos && !move_neg) [*2]) else $error("bad code not refused");
  AST_HERE: assert property (s_go ##0 (method == `HOMING_M_HERE) |=>
    ref_strobe && homed && position == $past(home_offset)) else $error("offset not taken");
  AST_NEG_FIRST: assert property (s_go ##0 (method inside {6'h01, 6'h11}) |->
    ##3 (move_neg && !move_pos && busy)) else $error("no negative travel");
  AST_POS_FIRST: assert property (s_go ##0 (method inside {6'h02, 6'h12}) |->
    ##3 (move_pos && !move_neg && busy)) else $error("no positive travel");
  AST_NEG_STOP: assert property (s_neg_hit |-> ##[1:3] !move_neg)
    else $error("ran into negative limit");
  AST_POS_STOP: assert property (s_pos_hit |-> ##[1:3] !move_pos)
    else $error("ran into positive limit");
  AST_STROBE: assert property (ref_strobe |-> homed ##1 !ref_strobe)
    else $error("reference pulse wrong");
endmodule // homing_checker

bind homing_sequence_selector homing_checker i_chk (.sys_clk(sys_clk), .resetn(resetn), .method(method),
  .start(start), .abort(abort), .saved_pos(saved_pos), .home_offset(home_offset), .lim_pos_pin(lim_pos_pin),
  .lim_neg_pin(lim_neg_pin), .move_pos(move_pos), .move_neg(move_neg), .busy(busy), .homed(homed),
  .invalid(invalid), .ref_strobe(ref_strobe), .position(position));

// ===== bench/tb_homing_sequence_selector.sv
// Self-checking bench of the homing sequence selector
`timescale 1ns/10ps
`include "homing_params.svh"
module tb_homing_sequence_selector;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [`HOMING_METHOD_W-1:0] method = 6'h00;
  logic start = 1'b0;
  logic abort = 1'b0;
  logic [`HOMING_POS_W-1:0] saved_pos = 32'h1234_5678;
  logic [`HOMING_POS_W-1:0] home_offset = 32'h0000_0abc;
  logic [`HOMING_POS_W-1:0] enc_count, ref_pos, position;
  logic lim_pos_pin, lim_neg_pin, home_sw_pin, enc_zero_pin;
  logic move_pos, move_neg, busy, homed, invalid, fault, ref_strobe;
  int error_cnt = 0;
  int num_checks = 0;

  homing_sequence_selector i_homing_sequence_selector (.sys_clk(sys_clk), .resetn(resetn), .method(method),
    .start(start), .abort(abort), .saved_pos(saved_pos), .home_offset(home_offset), .enc_count(enc_count),
    .lim_pos_pin(lim_pos_pin), .lim_neg_pin(lim_neg_pin), .home_sw_pin(home_sw_pin),
    .enc_zero_pin(enc_zero_pin), .move_pos(move_pos), .move_neg(move_neg), .busy(busy), .homed(homed),
    .invalid(invalid), .fault(fault), .ref_strobe(ref_strobe), .ref_pos(ref_pos), .position(position));
  axis_model i_axis_model (.sys_clk(sys_clk), .move_pos(move_pos), .move_neg(move_neg),
    .enc_count(enc_count), .lim_pos_pin(lim_pos_pin), .lim_neg_pin(lim_neg_pin),
    .home_sw_pin(home_sw_pin), .enc_zero_pin(enc_zero_pin));

  // 200 MHz clock
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Compare, count and report
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Start request, held for one edge only
  task automatic go(input logic [`HOMING_METHOD_W-1:0] m);
    @(negedge sys_clk);
    method = m;
    start = 1'b1;
    @(negedge sys_clk);
    start = 1'b0;
  endtask

  // Reset values, then the saved position
  task automatic t_reset();
    check("busy", 0, busy);
    check("position", 0, position);
    resetn = 1'b1;
    repeat (5) @(negedge sys_clk);
    check("position", saved_pos, position);
  endtask

  // Method zero: nothing moves
  task automatic t_none();
    go(`HOMING_M_NONE);
    repeat (4) @(negedge sys_clk);
    check("motion", 0, {move_pos, move_neg, busy});
    check("position", saved_pos, position);
  endtask

  // Undefined codes are refused
  task automatic t_bad();
    logic [5:0] codes [4] = '{6'h0f, 6'h10, 6'h1f, 6'h20};
    foreach (codes[i]) begin
      go(codes[i]);
      check("invalid", 1, invalid);
      repeat (3) @(negedge sys_clk);
      check("motion", 0, {move_pos, move_neg, busy});
    end
  endtask

  // Current position as reference
  task automatic t_here();
    go(`HOMING_M_HERE);
    check("strobe", 1, ref_strobe);
    check("position", home_offset, position);
    check("homed", 1, homed);
  endtask

  // Full search: first direction, then the captured count (exp < 0 skips it)
  task automatic t_ref(input logic [5:0] m, input int p, input logic dir_pos, input int exp);
    int n;
    n = 0;
    i_axis_model.pos = p;
    // Let the jump settle through the pin sync before starting
    repeat (4) @(negedge sys_clk);
    go(m);
    repeat (2) @(negedge sys_clk);
    check("direction", {dir_pos, !dir_pos}, {move_pos, move_neg});
    while (ref_strobe !== 1'b1 && n < 3000) begin
      @(negedge sys_clk);
      n++;
    end
    check("strobe", 1, ref_strobe);
    check("homed", 1, homed);
    if (exp >= 0) begin
      check("ref_pos", exp, ref_pos);
    end
    repeat (2) @(negedge sys_clk);
  endtask

  // Limit ahead with no turn allowed stops the search and flags it
  task automatic t_fault();
    int n;
    n = 0;
    i_axis_model.pos = 90;
    repeat (4) @(negedge sys_clk);
    go(6'h03);
    while (fault !== 1'b1 && n < 600) begin
      @(negedge sys_clk);
      n++;
    end
    repeat (2) @(negedge sys_clk);
    check("fault", 1, fault);
    check("halt", 0, {move_pos, move_neg, busy, homed, ref_strobe});
  endtask

  // Abort in mid-search stops the axis
  task automatic t_abort();
    i_axis_model.pos = 40;
    repeat (4) @(negedge sys_clk);
    go(6'h01);
    repeat (4) @(negedge sys_clk);
    abort = 1'b1;
    @(negedge sys_clk);
    abort = 1'b0;
    repeat (2) @(negedge sys_clk);
    check("abort", 0, {move_pos, move_neg, busy});
  endtask

  // Verdict and end of run
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Hang guard, well beyond the planned run
  initial begin
    repeat (60000) @(posedge sys_clk);
    error_cnt++;
    wrap_up();
  end

  initial begin
    repeat (20) @(negedge sys_clk);
    t_reset();
    t_none();
    t_bad();
    t_here();
    t_ref(6'h01, 40, 0, 5);
    t_ref(6'h02, 40, 1, 85);
    t_ref(6'h03, 40, 1, 53);
    t_ref(6'h04, 40, 1, 69);
    t_ref(6'h05, 90, 0, 85);
    t_ref(6'h06, 90, 0, 69);
    t_ref(6'h07, 90, 1, 53);
    t_ref(6'h08, 40, 1, 69);
    t_ref(6'h09, 40, 1, 69);
    t_ref(6'h0a, 40, 1, 85);
    t_ref(6'h0b, 90, 0, 85);
    t_ref(6'h0c, 90, 0, 69);
    t_ref(6'h0d, 90, 0, 69);
    t_ref(6'h0e, 40, 0, 53);
    t_ref(6'h11, 40, 0, 0);
    t_ref(6'h12, 40, 1, 100);
    t_ref(6'h13, 40, 1, 60);
    t_ref(6'h14, 40, 1, 60);
    t_ref(6'h15, 90, 0, 80);
    t_ref(6'h16, 90, 0, 80);
    t_ref(6'h17, 90, 1, 59);
    t_ref(6'h1e, 40, 0, 60);
    t_ref(6'h21, 40, 0, 37);
    t_ref(6'h22, 40, 1, 53);
    t_fault();
    t_abort();
    wrap_up();
  end
endmodule // tb_homing_sequence_selector
